/* File: rtl/bsu_pkg.sv */
package bsu_pkg;
    // widths
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PC_W = 16;
    localparam int GPR_AW = 5;
    localparam int IO_AW = 5;
    localparam int BUS_AW = 3;
    localparam int KOFF_W = 7;
    localparam int GPR_DEPTH = 32;

    // register offsets on the plain bus
    localparam logic [BUS_AW-1:0] ADDR_INSTR = 3'h0;
    localparam logic [BUS_AW-1:0] ADDR_NEXT = 3'h1;
    localparam logic [BUS_AW-1:0] ADDR_PC = 3'h2;
    localparam logic [BUS_AW-1:0] ADDR_STATUS = 3'h3;
    localparam logic [BUS_AW-1:0] ADDR_GPR_ADDR = 3'h4;
    localparam logic [BUS_AW-1:0] ADDR_GPR_DATA = 3'h5;
    localparam logic [BUS_AW-1:0] ADDR_STATE = 3'h6;

    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [WORD_W-1:0] INSTR_RESET = 16'h0000;

    // status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // state register read layout
    localparam int STATE_BUSY_BIT = 4;
    localparam int STATE_TAKEN_BIT = 5;

    // instruction classes in bits 15..12
    localparam logic [3:0] CLS_CMP_IMM = 4'h1;
    localparam logic [3:0] CLS_CMP_REG = 4'h2;
    localparam logic [3:0] CLS_SKIP = 4'h3;
    localparam logic [3:0] CLS_BR_SET = 4'h4;
    localparam logic [3:0] CLS_BR_CLR = 4'h5;
    localparam logic [3:0] CLS_IO_BIT = 4'h6;
    localparam logic [3:0] CLS_SHIFT = 4'h7;
    localparam logic [3:0] CLS_FLAG = 4'h8;
    localparam logic [3:0] CLS_TBIT = 4'h9;
    localparam logic [3:0] CLS_LONG = 4'hF;

    // variant field in bits 11..10
    localparam logic [1:0] SKV_REG_CLR = 2'h0;
    localparam logic [1:0] SKV_REG_SET = 2'h1;
    localparam logic [1:0] SKV_IO_CLR = 2'h2;
    localparam logic [1:0] SKV_IO_SET = 2'h3;

    // shift kinds in bits 2..0
    localparam logic [2:0] SH_LSL = 3'h0;
    localparam logic [2:0] SH_LSR = 3'h1;
    localparam logic [2:0] SH_ROL = 3'h2;
    localparam logic [2:0] SH_ROR = 3'h3;
    localparam logic [2:0] SH_ASR = 3'h4;
    localparam logic [2:0] SH_SWAP = 3'h5;

    localparam logic [GPR_AW-1:0] CPI_REG_BASE = 5'h10;

    // cycle counts and program counter steps
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_SHORT = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_LONG = 16'h0003;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_EXEC = 3'b100
    } bsu_state_e;

    // instruction field extraction
    function automatic logic [3:0] f_cls(input logic [WORD_W-1:0] w);
        return w[15:12];
    endfunction

    function automatic logic [1:0] f_var(input logic [WORD_W-1:0] w);
        return w[11:10];
    endfunction

    function automatic logic [GPR_AW-1:0] f_dst(input logic [WORD_W-1:0] w);
        return (w[15:12] == CLS_CMP_IMM) ? (CPI_REG_BASE | {1'b0, w[11:8]}) : w[9:5];
    endfunction

    function automatic logic [GPR_AW-1:0] f_src(input logic [WORD_W-1:0] w);
        return w[4:0];
    endfunction

    function automatic logic [2:0] f_bit(input logic [WORD_W-1:0] w);
        return w[2:0];
    endfunction

    function automatic logic [DATA_W-1:0] f_imm(input logic [WORD_W-1:0] w);
        return w[7:0];
    endfunction

    function automatic logic [KOFF_W-1:0] f_koff(input logic [WORD_W-1:0] w);
        return w[9:3];
    endfunction
endpackage

/* File: rtl/bsu_gpr_if.sv */
interface bsu_gpr_if;
    import bsu_pkg::*;
    logic [GPR_AW-1:0] raddr_a;
    logic [GPR_AW-1:0] raddr_b;
    logic [DATA_W-1:0] rdata_a;
    logic [DATA_W-1:0] rdata_b;
    logic [GPR_AW-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic we;

    modport ctrl (output raddr_a, output raddr_b, output waddr, output wdata, output we,
        input rdata_a, input rdata_b);
    modport mem (input raddr_a, input raddr_b, input waddr, input wdata, input we,
        output rdata_a, output rdata_b);
endinterface

/* File: rtl/bsu_gpr_mem.sv */
module bsu_gpr_mem
    import bsu_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    bsu_gpr_if.mem gp
);
    logic [DATA_W-1:0] mem_reg [GPR_DEPTH];

    // write port
    always_ff @(posedge clk)
    begin
        if (gp.we)
        begin
            mem_reg[gp.waddr] <= gp.wdata;
        end
    end

    // two registered read ports
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gp.rdata_a <= 8'h00;
            gp.rdata_b <= 8'h00;
        end
        else
        begin
            gp.rdata_a <= mem_reg[gp.raddr_a];
            gp.rdata_b <= mem_reg[gp.raddr_b];
        end
    end
endmodule

/* File: rtl/bsu_unit.sv */
module bsu_unit
    import bsu_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [BUS_AW-1:0] bus_addr,
    input wire logic [WORD_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [WORD_W-1:0] bus_rdata,
    output logic [IO_AW-1:0] io_addr,
    output logic [DATA_W-1:0] io_wdata,
    output logic io_we,
    output logic io_re,
    input wire logic [DATA_W-1:0] io_rdata,
    output logic busy
);
    bsu_gpr_if gp ();

    bsu_state_e state_reg;
    bsu_state_e state_next;
    logic [WORD_W-1:0] instr_reg;
    logic [WORD_W-1:0] next_reg;
    logic [PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] status_register_reg;
    logic [GPR_AW-1:0] gpr_addr_reg;
    logic [1:0] cycles_reg;
    logic taken_reg;
    logic busy_reg;
    logic [WORD_W-1:0] rdata_reg;
    logic io_re_reg;
    logic io_we_reg;
    logic [IO_AW-1:0] io_addr_reg;
    logic [DATA_W-1:0] io_wdata_reg;

    // results of the execute step
    logic [DATA_W-1:0] res;
    logic res_we;
    logic [DATA_W-1:0] status_register_new;
    logic [PC_W-1:0] pc_new;
    logic [1:0] cyc;
    logic taken;
    logic io_wr;
    logic [DATA_W-1:0] io_val;

    logic start;
    logic idle;

    // true when the instruction reads the io space
    function automatic logic f_uses_io(input logic [WORD_W-1:0] w);
        logic [1:0] v;
        logic io_skip;
        v = f_var(w);
        io_skip = (f_cls(w) == CLS_SKIP) && (v[1] == 1'b1);
        return io_skip || (f_cls(w) == CLS_IO_BIT);
    endfunction

    // flags of a subtraction d - k, result dropped
    function automatic logic [DATA_W-1:0] f_cmp_flags(input logic [DATA_W-1:0] s,
        input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] k);
        logic [DATA_W-1:0] r;
        logic [DATA_W-1:0] f;
        r = d - k;
        f = s;
        f[FLAG_H] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
        f[FLAG_V] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
        f[FLAG_N] = r[7];
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_C] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        return f;
    endfunction

    // flags of a shift or rotate
    function automatic logic [DATA_W-1:0] f_shift_flags(input logic [DATA_W-1:0] s,
        input logic [DATA_W-1:0] r, input logic c);
        logic [DATA_W-1:0] f;
        f = s;
        f[FLAG_C] = c;
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_N] = r[7];
        f[FLAG_V] = r[7] ^ c;
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        return f;
    endfunction

    assign idle = (state_reg == ST_IDLE);
    assign start = idle && bus_wr && (bus_addr == ADDR_INSTR);

    // register file ports: port a and write port give the bus view while idle, operands while running; port b always the source
    assign gp.raddr_a = idle ? gpr_addr_reg : f_dst(instr_reg);
    assign gp.raddr_b = f_src(instr_reg);
    assign gp.waddr = idle ? gpr_addr_reg : f_dst(instr_reg);
    assign gp.wdata = idle ? bus_wdata[DATA_W-1:0] : res;
    assign gp.we = idle ? (bus_wr && (bus_addr == ADDR_GPR_DATA)) : ((state_reg == ST_EXEC) && res_we);

    bsu_gpr_mem u_gpr (
        .clk(clk),
        .rstn(rstn),
        .gp(gp)
    );

    // sequencer
    always_comb
    begin
        case (state_reg)
            ST_IDLE: state_next = start ? ST_READ : ST_IDLE;
            ST_READ: state_next = ST_EXEC;
            ST_EXEC: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    // execute step
    always_comb
    begin
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] tb;
        logic [PC_W-1:0] koff;
        logic bitv;
        logic [1:0] vr;
        logic [KOFF_W-1:0] kf;
        vr = f_var(instr_reg);
        kf = f_koff(instr_reg);
        a = gp.rdata_a;
        tb = 8'h00;
        koff = {{(PC_W-KOFF_W){kf[KOFF_W-1]}}, kf};
        bitv = 1'b0;
        res = a;
        res_we = 1'b0;
        status_register_new = status_register_reg;
        pc_new = pc_reg + PC_STEP;
        cyc = CYC_ONE;
        taken = 1'b0;
        io_wr = 1'b0;
        io_val = io_rdata;
        case (f_cls(instr_reg))
            CLS_CMP_IMM:
            begin
                status_register_new = f_cmp_flags(status_register_reg, a, f_imm(instr_reg));
            end
            CLS_CMP_REG:
            begin
                status_register_new = f_cmp_flags(status_register_reg, a, gp.rdata_b);
            end
            CLS_SKIP:
            begin
                // register variants test the operand, io variants the io byte
                bitv = (vr[1] ? io_rdata[f_bit(instr_reg)] : a[f_bit(instr_reg)]);
                taken = (bitv == vr[0]);
                if (taken)
                begin
                    if (f_cls(next_reg) == CLS_LONG)
                    begin
                        pc_new = pc_reg + PC_SKIP_LONG;
                        cyc = CYC_THREE;
                    end
                    else
                    begin
                        pc_new = pc_reg + PC_SKIP_SHORT;
                        cyc = CYC_TWO;
                    end
                end
            end
            CLS_BR_SET, CLS_BR_CLR:
            begin
                // named branches are this test with a fixed flag index
                bitv = status_register_reg[f_bit(instr_reg)];
                taken = (f_cls(instr_reg) == CLS_BR_SET) ? bitv : ~bitv;
                if (taken)
                begin
                    pc_new = pc_reg + koff + PC_STEP;
                    cyc = CYC_TWO;
                end
            end
            CLS_IO_BIT:
            begin
                io_wr = 1'b1;
                io_val[f_bit(instr_reg)] = vr[0];
                cyc = CYC_TWO;
            end
            CLS_SHIFT:
            begin
                res_we = 1'b1;
                case (f_bit(instr_reg))
                    SH_LSL:
                    begin
                        res = {a[6:0], 1'b0};
                        status_register_new = f_shift_flags(status_register_reg, res, a[7]);
                    end
                    SH_LSR:
                    begin
                        res = {1'b0, a[7:1]};
                        status_register_new = f_shift_flags(status_register_reg, res, a[0]);
                    end
                    SH_ROL:
                    begin
                        res = {a[6:0], status_register_reg[FLAG_C]};
                        status_register_new = f_shift_flags(status_register_reg, res, a[7]);
                    end
                    SH_ROR:
                    begin
                        res = {status_register_reg[FLAG_C], a[7:1]};
                        status_register_new = f_shift_flags(status_register_reg, res, a[0]);
                    end
                    SH_ASR:
                    begin
                        res = {a[7], a[7:1]};
                        status_register_new = f_shift_flags(status_register_reg, res, a[0]);
                    end
                    SH_SWAP:
                    begin
                        res = {a[3:0], a[7:4]};
                    end
                    default:
                    begin
                        res_we = 1'b0;
                    end
                endcase
            end
            CLS_FLAG:
            begin
                status_register_new[f_bit(instr_reg)] = vr[0];
            end
            CLS_TBIT:
            begin
                if (vr[0])
                begin
                    tb = a;
                    tb[f_bit(instr_reg)] = status_register_reg[FLAG_T];
                    res = tb;
                    res_we = 1'b1;
                end
                else
                begin
                    status_register_new[FLAG_T] = a[f_bit(instr_reg)];
                end
            end
            default:
            begin
                res_we = 1'b0;
            end
        endcase
    end

    // instruction words
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            instr_reg <= INSTR_RESET;
            next_reg <= INSTR_RESET;
        end
        else if (idle && bus_wr)
        begin
            if (bus_addr == ADDR_INSTR)
            begin
                instr_reg <= bus_wdata;
            end
            if (bus_addr == ADDR_NEXT)
            begin
                next_reg <= bus_wdata;
            end
        end
    end

    // program counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc_reg <= PC_RESET;
        end
        else if (state_reg == ST_EXEC)
        begin
            pc_reg <= pc_new;
        end
        else if (idle && bus_wr && (bus_addr == ADDR_PC))
        begin
            pc_reg <= bus_wdata;
        end
    end

    // status register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_register_reg <= STATUS_RESET;
        end
        else if (state_reg == ST_EXEC)
        begin
            status_register_reg <= status_register_new;
        end
        else if (idle && bus_wr && (bus_addr == ADDR_STATUS))
        begin
            status_register_reg <= bus_wdata[DATA_W-1:0];
        end
    end

    // register file index for bus access
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gpr_addr_reg <= '0;
        end
        else if (idle && bus_wr && (bus_addr == ADDR_GPR_ADDR))
        begin
            gpr_addr_reg <= bus_wdata[GPR_AW-1:0];
        end
    end

    // cycle count and taken flag of the last instruction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cycles_reg <= 2'h0;
            taken_reg <= 1'b0;
        end
        else if (state_reg == ST_EXEC)
        begin
            cycles_reg <= cyc;
            taken_reg <= taken;
        end
    end

    // io space access: read while fetching operands, write after execute
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            io_re_reg <= 1'b0;
            io_we_reg <= 1'b0;
            io_addr_reg <= '0;
            io_wdata_reg <= 8'h00;
        end
        else
        begin
            io_re_reg <= start && f_uses_io(bus_wdata);
            io_we_reg <= (state_reg == ST_EXEC) && io_wr;
            if (start)
            begin
                io_addr_reg <= f_dst(bus_wdata);
            end
            if ((state_reg == ST_EXEC) && io_wr)
            begin
                io_wdata_reg <= io_val;
            end
        end
    end

    // bus read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_reg <= '0;
        end
        else if (bus_rd)
        begin
            case (bus_addr)
                ADDR_INSTR: rdata_reg <= instr_reg;
                ADDR_NEXT: rdata_reg <= next_reg;
                ADDR_PC: rdata_reg <= pc_reg;
                ADDR_STATUS: rdata_reg <= {8'h00, status_register_reg};
                ADDR_GPR_ADDR: rdata_reg <= {11'h000, gpr_addr_reg};
                ADDR_GPR_DATA: rdata_reg <= {8'h00, gp.rdata_a};
                ADDR_STATE:
                begin
                    rdata_reg <= '0;
                    rdata_reg[1:0] <= cycles_reg;
                    rdata_reg[STATE_BUSY_BIT] <= busy_reg;
                    rdata_reg[STATE_TAKEN_BIT] <= taken_reg;
                end
                default: rdata_reg <= '0;
            endcase
        end
        else
        begin
            rdata_reg <= '0;
        end
    end

    // outputs straight from flops
    assign bus_rdata = rdata_reg;
    assign io_addr = io_addr_reg;
    assign io_wdata = io_wdata_reg;
    assign io_we = io_we_reg;
    assign io_re = io_re_reg;
    assign busy = busy_reg;
endmodule

/* File: tb/bsu_unit_checker.sv */
module bsu_unit_checker
    import bsu_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [BUS_AW-1:0] bus_addr,
    input wire logic [WORD_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [WORD_W-1:0] bus_rdata,
    input wire logic [IO_AW-1:0] io_addr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [DATA_W-1:0] io_rdata,
    input wire logic busy
);
    logic [WORD_W-1:0] ins_reg;
    logic [DATA_W-1:0] msk;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // instruction word kept for the io checks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ins_reg <= 16'h0000;
        else if (bus_wr && bus_addr == ADDR_INSTR && !busy)
            ins_reg <= bus_wdata;
    end
    // bit picked by the held word
    assign msk = 8'h01 << ins_reg[2:0];
    sequence s_start;
        bus_wr && bus_addr == ADDR_INSTR && !busy;
    endsequence
    sequence s_run;
        busy [*2] ##1 !busy;
    endsequence
    sequence s_io_op;
        s_start ##0 bus_wdata[15:12] == CLS_IO_BIT;
    endsequence
    sequence s_io_skip;
        s_start ##0 bus_wdata[15:11] == {CLS_SKIP, 1'b1};
    endsequence
    a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
        else $error("read data not zero outside answer");
    a_busy_run: assert property (s_start |=> s_run)
        else $error("busy window wrong");
    a_busy_cause: assert property ($rose(busy) |-> $past(bus_wr && bus_addr == ADDR_INSTR))
        else $error("busy without instruction");
    a_io_skip_read: assert property (s_io_skip |=> io_re && io_addr == $past(bus_wdata[9:5]))
        else $error("io skip did not read its port");
    a_io_bit_rmw: assert property (s_io_op |=> io_re ##2 io_we && io_addr == ins_reg[9:5])
        else $error("io bit op not read then written");
    a_io_bit_value: assert property (io_we |->
        io_wdata == (ins_reg[10] ? ($past(io_rdata) | msk) : ($past(io_rdata) & ~msk)))
        else $error("io bit op wrote wrong value");
    a_io_write_kind: assert property (io_we |-> ins_reg[15:12] == CLS_IO_BIT)
        else $error("io write from wrong instruction");
    a_io_read_kind: assert property (io_re |-> busy &&
        (ins_reg[15:12] == CLS_IO_BIT || ins_reg[15:11] == {CLS_SKIP, 1'b1}))
        else $error("io read from wrong instruction");
    a_io_idle_quiet: assert property (!busy && !$past(busy) |-> !io_re && !io_we)
        else $error("io strobe while idle");
    a_io_pulse_once: assert property (io_re || io_we |=> !io_re && !io_we)
        else $error("io strobe longer than one cycle");
endmodule

bind bsu_unit bsu_unit_checker bsu_unit_checker_inst (.clk, .rstn, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .busy);

/* File: tb/bsu_unit_tb.sv */
module bsu_unit_tb
    import bsu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [BUS_AW-1:0] bus_addr = 3'h0;
    logic [WORD_W-1:0] bus_wdata = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [WORD_W-1:0] bus_rdata, g;
    logic [IO_AW-1:0] io_addr;
    logic [DATA_W-1:0] io_wdata, io_got;
    logic [DATA_W-1:0] io_rdata = 8'h00;
    logic [DATA_W-1:0] io_val = 8'h00;
    logic io_we, io_re, busy;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    bsu_unit bsu_unit_inst (.clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .busy);

    // clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    // io port answer, changing every cycle when not read
    always @(posedge clk)
    begin
        io_rdata <= io_re ? io_val : ~io_rdata;
        if (io_we)
            io_got <= io_wdata;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [BUS_AW-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [BUS_AW-1:0] a);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 g = bus_rdata;
    endtask

    task automatic setr(input logic [4:0] a, input logic [7:0] d);
        wr(ADDR_GPR_ADDR, {11'h000, a});
        wr(ADDR_GPR_DATA, {8'h00, d});
    endtask

    task automatic getr(input logic [4:0] a);
        wr(ADDR_GPR_ADDR, {11'h000, a});
        rd(ADDR_GPR_DATA);
    endtask

    // load pc and flags, execute one word, check pc, flags and cycle count
    task automatic run(input logic [7:0] st, input logic [3:0] nc, input logic [WORD_W-1:0] ins,
        input logic [WORD_W-1:0] epc, input logic [7:0] est, input logic tk, input logic [1:0] cyc);
        wr(ADDR_PC, 16'h0100);
        wr(ADDR_STATUS, {8'h00, st});
        wr(ADDR_NEXT, {nc, 12'h000});
        wr(ADDR_INSTR, ins);
        @(posedge clk);
        rd(ADDR_PC);
        chk(g, epc);
        rd(ADDR_STATUS);
        chk(g, {8'h00, est});
        rd(ADDR_STATE);
        chk(g, {10'h000, tk, 3'h0, cyc});
    endtask

    task automatic t_reset();
        rd(ADDR_PC);
        chk(g, PC_RESET);
        rd(ADDR_STATUS);
        chk(g, {8'h00, STATUS_RESET});
        rd(3'h7);
        chk(g, 16'h0000);
        // unknown class is a one cycle no-op
        run(8'h5A, 4'h0, 16'h0000, 16'h0101, 8'h5A, 1'b0, 2'h1);
    endtask

    task automatic t_compare();
        setr(5'h10, 8'h10);
        run(8'h00, 4'h0, 16'h1020, 16'h0101, 8'h15, 1'b0, 2'h1);
        getr(5'h10);
        chk(g, 16'h0010);
        setr(5'h01, 8'h80);
        setr(5'h02, 8'h01);
        run(8'h00, 4'h0, 16'h2022, 16'h0101, 8'h38, 1'b0, 2'h1);
        getr(5'h01);
        chk(g, 16'h0080);
    endtask

    // every flag, both senses, backward and forward offsets
    task automatic t_branch();
        logic [6:0] k;
        logic [7:0] st;
        logic tk;
        for (int c = 0; c < 2; c++)
            for (int s = 0; s < 8; s++)
                for (int b = 0; b < 2; b++)
                begin
                    k = c ? 7'h3F : 7'h7D;
                    tk = (b == 1) == (c == 0);
                    st = b ? 8'h01 << s : ~(8'h01 << s);
                    run(st, 4'h0, {c ? CLS_BR_CLR : CLS_BR_SET, 2'h0, k, s[2:0]},
                        tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101, st, tk, tk ? 2'h2 : 2'h1);
                end
    endtask

    // register and io skips over short and long words
    task automatic t_skip();
        int n;
        logic tk;
        setr(5'h03, 8'h04);
        io_val <= 8'hFB; // io bit two clear while register bit two is set
        for (int v = 0; v < 4; v++)
            for (int l = 0; l < 2; l++)
            begin
                tk = v[0] ^ v[1];
                n = tk ? 2 + l : 1;
                run(8'hA5, l ? CLS_LONG : 4'h0, {CLS_SKIP, v[1:0], 5'h03, 5'h02},
                    16'h0100 + n[15:0], 8'hA5, tk, n[1:0]);
            end
    endtask

    task automatic t_io_bit();
        io_val <= 8'h00;
        run(8'h5A, 4'h0, {CLS_IO_BIT, 2'h1, 5'h09, 5'h03}, 16'h0101, 8'h5A, 1'b0, 2'h2);
        chk({8'h00, io_got}, 16'h0008);
        io_val <= 8'hFF;
        run(8'h5A, 4'h0, {CLS_IO_BIT, 2'h0, 5'h09, 5'h03}, 16'h0101, 8'h5A, 1'b0, 2'h2);
        chk({8'h00, io_got}, 16'h00F7);
    endtask

    // shift kinds in encoding order with carry in and expected flags
    task automatic t_shift();
        logic [7:0] din [6] = '{8'h81, 8'h81, 8'h40, 8'h01, 8'h83, 8'h3C};
        logic [7:0] dq [6] = '{8'h02, 8'h40, 8'h81, 8'h00, 8'hC1, 8'hC3};
        logic [7:0] sa [6] = '{8'hE0, 8'hE0, 8'hE1, 8'hE0, 8'hE0, 8'hE1};
        logic [7:0] sb [6] = '{8'hF9, 8'hF9, 8'hEC, 8'hFB, 8'hF5, 8'hE1};
        for (int i = 0; i < 6; i++)
        begin
            setr(5'h05, din[i]);
            run(sa[i], 4'h0, {CLS_SHIFT, 2'h0, 5'h05, 2'h0, i[2:0]}, 16'h0101, sb[i], 1'b0, 2'h1);
            getr(5'h05);
            chk(g, {8'h00, dq[i]});
        end
    endtask

    task automatic t_flag();
        for (int s = 0; s < 8; s++)
        begin
            run(8'h00, 4'h0, {CLS_FLAG, 2'h1, 7'h00, s[2:0]}, 16'h0101, 8'h01 << s, 1'b0, 2'h1);
            run(8'hFF, 4'h0, {CLS_FLAG, 2'h0, 7'h00, s[2:0]}, 16'h0101, ~(8'h01 << s), 1'b0, 2'h1);
        end
        setr(5'h07, 8'h10);
        run(8'h00, 4'h0, {CLS_TBIT, 2'h0, 5'h07, 5'h04}, 16'h0101, 8'h40, 1'b0, 2'h1);
        setr(5'h08, 8'h00);
        run(8'h40, 4'h0, {CLS_TBIT, 2'h1, 5'h08, 5'h06}, 16'h0101, 8'h40, 1'b0, 2'h1);
        getr(5'h08);
        chk(g, 16'h0040);
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_compare();
        t_branch();
        t_skip();
        t_io_bit();
        t_shift();
        t_flag();
        stop_test();
    end
endmodule
